// file: reflex_pkg.sv
// Constants and types for the reflex start-up and fallback control
// Behaviour
// - Power-up or reconfigure: fallback with factory defaults
// - User fallback only after all inputs arrived; code: stop-run or swap forces it at once
// - All inputs received enters run, user fallback if erroneous
// - Input status error drives user fallback value
// - Enable treated like operational inputs
// - Missing peer module keeps all blocks factory fallback
// - Stop then run resets to user fallback
// - Mandatory module swap resets to user fallback
// - Fieldbus cable loss leaves reflex blocks running
// - Error clears after full inputs and enable seen
// - Error: ready indicator three blinks then pause
// - Errors send emergency and node error 0x80
// - Constant-true enable runs immediately at start-up
// - Constant-false enable: fallback, flash, error never clears
// - Low enable fallback sends emergency, node error
// - Island enable reading 0 starts in fallback
// - Enable sensed active: run, indicator steady on
package reflex_pkg;
   localparam int NUM_BLOCKS = 2;
   localparam int NUM_INPUTS = 3;
   // APB register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_ENSRC = 8'h04;
   localparam logic [7:0] OFF_FBCFG = 8'h08;
   localparam logic [7:0] OFF_STATE = 8'h0C;
   localparam logic [7:0] OFF_NODE_ERR = 8'h10;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFF_PRESCALE = 8'h1C;
   // Control register bit positions
   localparam int CTRL_STOP = 0;
   localparam int CTRL_RUN = 1;
   localparam int CTRL_SWAP = 2;
   // Interrupt status bit positions
   localparam int IRQ_ERR_SET = 0;
   localparam int IRQ_ERR_CLR = 1;
   localparam int IRQ_EMCY = 2;
   localparam logic [7:0] NODE_ERR_REFLEX = 8'h80;
   localparam logic [7:0] NODE_ERR_NONE = 8'h00;
   localparam logic [15:0] PRESCALE_RESET = 16'h0FFF;
   localparam logic [2:0] BLINK_COUNT = 3'h3;
   localparam logic [3:0] PAUSE_TICKS = 4'h8;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   // Enable source encodings
   typedef enum logic [1:0]
   {
      ENSRC_ALWAYS = 2'h0,
      ENSRC_NEVER = 2'h1,
      ENSRC_INPUT = 2'h2
   } en_src_t;
   typedef enum logic [2:0]
   {
      ST_FACTORY_FB = 3'b001,
      ST_RUN = 3'b010,
      ST_USER_FB = 3'b100
   } blk_state_t;
endpackage : reflex_pkg

// file: reflex_startup_fallback_control.sv
// Start-up, fallback and indicator control for reflex blocks
`timescale 1ns/1ps
module reflex_startup_fallback_control
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Island bus input status, per block and input
   input wire logic [reflex_pkg::NUM_BLOCKS*reflex_pkg::NUM_INPUTS-1:0] in_received,
   input wire logic [reflex_pkg::NUM_BLOCKS*reflex_pkg::NUM_INPUTS-1:0] in_status_err,
   input wire logic [reflex_pkg::NUM_BLOCKS-1:0] enable_in,
   input wire logic peer_all_present,
   input wire logic mandatory_module_swap,
   input wire logic fieldbus_link_up,
   // Per-block results from the reflex operations
   input wire logic [reflex_pkg::NUM_BLOCKS-1:0] op_value,
   // Outputs
   output logic [reflex_pkg::NUM_BLOCKS-1:0] chan_out,
   output logic [reflex_pkg::NUM_BLOCKS-1:0] chan_fallback,
   output logic ready_led,
   output logic emcy_pulse,
   output logic irq
);
   import reflex_pkg::*;

   localparam int NB = NUM_BLOCKS;
   localparam int NI = NUM_INPUTS;

   // Registers
   logic [2*NB-1:0] en_src;
   logic [2*NB-1:0] fb_cfg;
   logic [15:0] prescale;
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   logic [7:0] node_err;
   logic stop_seen;
   blk_state_t st [NB];
   logic [NB-1:0] en_seen;
   logic [NB-1:0] blk_err;
   logic any_err_q;
   logic [15:0] pre_cnt;
   logic tick;
   logic [2:0] blink_num;
   logic blink_phase;
   logic [3:0] pause_cnt;

   logic wr_en;
   logic rd_en;
   logic restart_user;
   logic [NB-1:0] all_in;
   logic [NB-1:0] any_serr;
   logic [NB-1:0] en_eff;
   logic [NB-1:0] fb_cond;
   logic any_err;
   logic hold_err;
   logic [31:0] next_prdata;

   function automatic logic en_value(input logic [1:0] src, input logic pin);
      unique case (src)
         ENSRC_ALWAYS: en_value = 1'b1;
         ENSRC_INPUT: en_value = pin;
         default: en_value = 1'b0;
      endcase
   endfunction : en_value

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;

   // Stop followed by run, or mandatory module swap, restarts in user fallback
   assign restart_user = (wr_en && paddr == OFF_CTRL && pwdata[CTRL_RUN] && stop_seen)
                         || mandatory_module_swap
                         || (wr_en && paddr == OFF_CTRL && pwdata[CTRL_SWAP]);

   always_comb
   begin
      for (int b = 0; b < NB; b++)
      begin
         all_in[b] = &in_received[b*NI +: NI] && peer_all_present;
         any_serr[b] = |in_status_err[b*NI +: NI];
         en_eff[b] = en_value(en_src[2*b +: 2], enable_in[b]);
         fb_cond[b] = any_serr[b] || !en_eff[b];
      end
   end

   // Fieldbus link deliberately not consulted: reflex runs on peer data only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int b = 0; b < NB; b++)
         begin
            st[b] <= ST_FACTORY_FB;
         end
      end
      else
      begin
         for (int b = 0; b < NB; b++)
         begin
            if (restart_user)
            begin
               st[b] <= ST_USER_FB;
            end
            else
            begin
               unique case (st[b])
                  ST_FACTORY_FB:
                  begin
                     if (&all_in)
                     begin
                        st[b] <= fb_cond[b] ? ST_USER_FB : ST_RUN;
                     end
                  end
                  ST_RUN:
                  begin
                     if (fb_cond[b] || !all_in[b])
                     begin
                        st[b] <= ST_USER_FB;
                     end
                  end
                  ST_USER_FB:
                  begin
                     if (all_in[b] && !fb_cond[b])
                     begin
                        st[b] <= ST_RUN;
                     end
                  end
                  default: st[b] <= ST_FACTORY_FB;
               endcase
            end
         end
      end
   end

   // Error clears only after clean data and enable seen while data present
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_seen <= '0;
         blk_err <= '1;
      end
      else
      begin
         for (int b = 0; b < NB; b++)
         begin
            if (restart_user || !all_in[b] || any_serr[b] || en_src[2*b +: 2] == ENSRC_NEVER)
            begin
               en_seen[b] <= 1'b0;
               blk_err[b] <= 1'b1;
            end
            else if (en_eff[b] || en_seen[b])
            begin
               en_seen[b] <= 1'b1;
               blk_err[b] <= 1'b0;
            end
            else
            begin
               blk_err[b] <= 1'b1;
            end
         end
      end
   end

   assign any_err = |blk_err || st[0] != ST_RUN || st[NB-1] != ST_RUN;

   // Low enable keeps the error reported even after the block has run once
   assign hold_err = |blk_err || |(~en_eff);

   // Channel outputs: factory fallback is off, user fallback from config
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         chan_out <= '0;
         chan_fallback <= '1;
      end
      else
      begin
         for (int b = 0; b < NB; b++)
         begin
            unique case (st[b])
               ST_RUN:
               begin
                  chan_out[b] <= op_value[b];
                  chan_fallback[b] <= 1'b0;
               end
               ST_USER_FB:
               begin
                  chan_out[b] <= fb_cfg[2*b] ? fb_cfg[2*b+1] : chan_out[b];
                  chan_fallback[b] <= 1'b1;
               end
               default:
               begin
                  chan_out[b] <= 1'b0;
                  chan_fallback[b] <= 1'b1;
               end
            endcase
         end
      end
   end

   // Prescaled tick for blink timing
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_cnt <= '0;
         tick <= 1'b0;
      end
      else if (pre_cnt >= prescale)
      begin
         pre_cnt <= '0;
         tick <= 1'b1;
      end
      else
      begin
         pre_cnt <= pre_cnt + 16'h0001;
         tick <= 1'b0;
      end
   end

   // Three blinks then a pause, else steady on
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         blink_num <= '0;
         blink_phase <= 1'b0;
         pause_cnt <= '0;
         ready_led <= 1'b0;
      end
      else if (!any_err)
      begin
         blink_num <= '0;
         blink_phase <= 1'b0;
         pause_cnt <= '0;
         ready_led <= 1'b1;
      end
      else if (tick)
      begin
         if (blink_num < BLINK_COUNT)
         begin
            blink_phase <= !blink_phase;
            ready_led <= !blink_phase;
            if (blink_phase)
            begin
               blink_num <= blink_num + 3'h1;
            end
         end
         else
         begin
            // Wrap on the last pause tick so a period is exactly 14 ticks
            ready_led <= 1'b0;
            if (pause_cnt == PAUSE_TICKS - 4'h1)
            begin
               blink_num <= '0;
               pause_cnt <= '0;
            end
            else
            begin
               pause_cnt <= pause_cnt + 4'h1;
            end
         end
      end
   end

   // Node error register and emergency event on error entry
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         any_err_q <= 1'b0;
         emcy_pulse <= 1'b0;
         node_err <= NODE_ERR_NONE;
      end
      else
      begin
         any_err_q <= hold_err;
         emcy_pulse <= hold_err && !any_err_q;
         node_err <= hold_err ? NODE_ERR_REFLEX : NODE_ERR_NONE;
      end
   end

   // Configuration registers; stop sets a flag that the next run consumes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_src <= '0;
         fb_cfg <= '0;
         prescale <= PRESCALE_RESET;
         irq_mask <= '0;
         stop_seen <= 1'b0;
      end
      else if (wr_en)
      begin
         unique case (paddr)
            OFF_CTRL:
            begin
               if (pwdata[CTRL_STOP])
               begin
                  stop_seen <= 1'b1;
               end
               else if (pwdata[CTRL_RUN])
               begin
                  stop_seen <= 1'b0;
               end
            end
            OFF_ENSRC: en_src <= pwdata[2*NB-1:0];
            OFF_FBCFG: fb_cfg <= pwdata[2*NB-1:0];
            OFF_PRESCALE: prescale <= pwdata[15:0];
            OFF_IRQ_MASK: irq_mask <= pwdata[2:0];
            default:
            begin
            end
         endcase
      end
   end

   // Sticky events, write one to clear; a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat <= '0;
         irq <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            logic ev;
            ev = 1'b0;
            unique case (i)
               IRQ_ERR_SET: ev = hold_err && !any_err_q;
               IRQ_ERR_CLR: ev = !hold_err && any_err_q;
               default: ev = hold_err && !any_err_q;
            endcase
            if (ev)
            begin
               irq_stat[i] <= 1'b1;
            end
            else if (wr_en && paddr == OFF_IRQ_STAT && pwdata[i])
            begin
               irq_stat[i] <= 1'b0;
            end
         end
         irq <= |(irq_stat & irq_mask);
      end
   end

   always_comb
   begin
      next_prdata = ZERO_WORD;
      unique case (paddr)
         OFF_CTRL: next_prdata[0] = stop_seen;
         OFF_ENSRC: next_prdata[2*NB-1:0] = en_src;
         OFF_FBCFG: next_prdata[2*NB-1:0] = fb_cfg;
         OFF_STATE:
         begin
            next_prdata[NB-1:0] = blk_err;
            next_prdata[8 +: NB] = chan_fallback;
            next_prdata[16] = fieldbus_link_up;
         end
         OFF_NODE_ERR: next_prdata[7:0] = node_err;
         OFF_IRQ_STAT: next_prdata[2:0] = irq_stat;
         OFF_IRQ_MASK: next_prdata[2:0] = irq_mask;
         OFF_PRESCALE: next_prdata[15:0] = prescale;
         default: next_prdata = ZERO_WORD;
      endcase
   end

   // Read data latched in setup, answer in first access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= ZERO_WORD;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         if (rd_en)
         begin
            prdata <= next_prdata;
         end
         pready <= psel && !penable;
         pslverr <= psel && !penable && paddr > OFF_PRESCALE;
      end
   end
endmodule : reflex_startup_fallback_control

// file: reflex_ctrl_props.sv
// Assertion checker for the reflex start-up control ports
`timescale 1ns/1ps
module reflex_ctrl_props
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus and island side
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic [5:0] in_status_err,
   input wire logic peer_all_present,
   // Outputs
   input wire logic [1:0] chan_fallback,
   input wire logic emcy_pulse,
   input wire logic ready_led
);
   int unsigned lit;
   // Bounds a steady lamp while a block is held back
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         lit <= 0;
      else
         lit <= (ready_led && chan_fallback != 2'b00) ? lit + 1 : 0;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_reset_factory: assert property (!$past(presetn) |-> chan_fallback == 2'b11)
      else $error("fallback missing after reset");
   chk_peer_absent: assert property ((!peer_all_present)[*3] |-> chan_fallback == 2'b11)
      else $error("block left fallback without peers");
   chk_status_fb: assert property ((|in_status_err[2:0])[*3] |-> chan_fallback[0])
      else $error("status error without fallback");
   chk_emcy_pulse: assert property (emcy_pulse |=> !emcy_pulse)
      else $error("emergency pulse too long");
   chk_led_steady: assert property ((chan_fallback == 2'b00)[*4] |-> ready_led)
      else $error("lamp not steady while running");
   chk_led_blinks: assert property (lit < 70000)
      else $error("lamp stuck on during fallback");
   chk_apb_answer: assert property (psel && !penable |=> pready)
      else $error("no zero-wait answer");
   chk_pready_pulse: assert property (pready |=> !pready)
      else $error("pready held two cycles");
endmodule : reflex_ctrl_props
bind reflex_startup_fallback_control reflex_ctrl_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .in_status_err(in_status_err), .peer_all_present(peer_all_present),
   .chan_fallback(chan_fallback), .emcy_pulse(emcy_pulse), .ready_led(ready_led));

// file: island_peer_model.sv
// Island bus peer model: input arrival, status and enable
`timescale 1ns/1ps
module island_peer_model
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench commands
   input wire logic present,
   input wire logic [5:0] err_mask,
   input wire logic [1:0] en,
   input wire logic swap_req,
   input wire logic [7:0] lag,
   // Island side
   output logic [5:0] in_received,
   output logic [5:0] in_status_err,
   output logic [1:0] enable_in,
   output logic peer_all_present,
   output logic mandatory_module_swap
);
   int cnt;
   logic swap_q;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cnt <= 0;
         in_received <= 6'h00;
         in_status_err <= 6'h00;
         enable_in <= 2'h0;
         peer_all_present <= 1'b0;
         swap_q <= 1'b0;
         mandatory_module_swap <= 1'b0;
      end
      else
      begin
         cnt <= present ? ((cnt < int'(lag)) ? cnt + 1 : cnt) : 0;
         in_received <= (present && cnt >= int'(lag)) ? 6'h3F : 6'h00;
         // Status means nothing before arrival, so it churns
         in_status_err <= (present && cnt >= int'(lag)) ? err_mask : ~in_status_err;
         peer_all_present <= present;
         enable_in <= en;
         swap_q <= swap_req;
         mandatory_module_swap <= swap_req && !swap_q;
      end
endmodule : island_peer_model

// file: reflex_startup_fallback_control_bench.sv
// Self-checking bench for reflex start-up and fallback control
`timescale 1ns/1ps
module reflex_startup_fallback_control_bench;
   import reflex_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, swp = 0, pres = 0, led_q, rerr;
   logic pready, pslverr, ready_led, emcy_pulse, irq, fieldbus_link_up = 0, peer_all_present, mandatory_module_swap;
   logic [7:0] paddr = 8'h00, lag = 8'h03;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic [5:0] in_received, in_status_err, errm = 6'h00;
   logic [1:0] enable_in, en = 2'h0, op_value = 2'h0, chan_out, chan_fallback;
   int n_errors = 0, check_count = 0, seed = 49224, cycles = 0, k, user = 0, n_emcy = 0;
   int src [2] = '{0, 0};
   always #25 pclk = ~pclk;
   reflex_startup_fallback_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .in_received(in_received), .in_status_err(in_status_err), .enable_in(enable_in),
      .peer_all_present(peer_all_present), .mandatory_module_swap(mandatory_module_swap),
      .fieldbus_link_up(fieldbus_link_up), .op_value(op_value), .chan_out(chan_out),
      .chan_fallback(chan_fallback), .ready_led(ready_led), .emcy_pulse(emcy_pulse), .irq(irq));
   island_peer_model i_peer (.pclk(pclk), .presetn(presetn), .present(pres), .err_mask(errm), .en(en),
      .swap_req(swp), .lag(lag), .in_received(in_received), .in_status_err(in_status_err),
      .enable_in(enable_in), .peer_all_present(peer_all_present), .mandatory_module_swap(mandatory_module_swap));
   task automatic report_and_stop;
      $display("Checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", name, exp, got);
         n_errors++;
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ends once pready is seen high; only the bench timeout bounds this wait
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Expected outputs from the model state
   task automatic settle;
      logic [1:0] f;
      repeat (14) @(posedge pclk);
      for (int b = 0; b < 2; b++)
         f[b] = !pres || (|errm[3*b+:3]) || src[b] == 1 || (src[b] == 2 && !en[b]);
      chk("chan_fallback", 32'(f), 32'(chan_fallback));
      chk("chan_out", 32'((f & (user != 0 ? 2'h3 : 2'h0)) | (~f & op_value)), 32'(chan_out));
   endtask : settle
   always @(posedge pclk)
   begin
      cycles++;
      n_emcy += int'(emcy_pulse === 1'b1);
      fieldbus_link_up <= 1'($random(seed));
      if (cycles == 5000)
      begin
         n_errors++;
         report_and_stop();
      end
   end
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      apb(1'b0, 8'h20, 32'h0);
      chk("slverr", 32'h1, 32'(rerr));
      apb(1'b0, OFF_PRESCALE, 32'h0);
      chk("prescale", 32'h0000_0FFF, rdat);
      apb(1'b1, OFF_PRESCALE, 32'h2);
      apb(1'b1, OFF_FBCFG, 32'hF);
      apb(1'b1, OFF_ENSRC, 32'h0);
      apb(1'b1, OFF_IRQ_MASK, 32'h1);
      op_value <= 2'($random(seed));
      pres <= 1'b1;
      settle();
      user = 1;
      chk("ready_led", 32'h1, 32'(ready_led));
      apb(1'b0, OFF_NODE_ERR, 32'h0);
      chk("node_err", 32'h0, rdat);
      k = n_emcy;
      errm <= 6'h01;
      settle();
      chk("emcy_count", 32'h1, 32'(n_emcy - k));
      apb(1'b0, OFF_NODE_ERR, 32'h0);
      chk("node_err", 32'h80, rdat);
      chk("irq", 32'h1, 32'(irq));
      apb(1'b1, OFF_IRQ_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h0, 32'(irq));
      k = 0;
      led_q = ready_led;
      // Two whole periods of 14 ticks of 3 cycles
      repeat (84)
      begin
         @(posedge pclk);
         k += int'(ready_led && !led_q);
         led_q = ready_led;
      end
      chk("blinks", 32'h6, 32'(k));
      errm <= 6'h00;
      settle();
      apb(1'b1, OFF_IRQ_STAT, 32'h7);
      apb(1'b1, OFF_IRQ_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h0, 32'(irq));
      src = '{2, 1};
      apb(1'b1, OFF_ENSRC, 32'h6);
      settle();
      apb(1'b0, OFF_NODE_ERR, 32'h0);
      chk("node_err", 32'h80, rdat);
      en <= 2'h1;
      settle();
      src = '{2, 2};
      en <= 2'h0;
      apb(1'b1, OFF_ENSRC, 32'hA);
      apb(1'b1, OFF_CTRL, 32'h1);
      apb(1'b1, OFF_CTRL, 32'h2);
      settle();
      swp <= 1'b1;
      repeat (2) @(posedge pclk);
      swp <= 1'b0;
      settle();
      src = '{0, 0};
      apb(1'b1, OFF_ENSRC, 32'h0);
      lag <= 8'h00;
      op_value <= 2'($random(seed));
      settle();
      report_and_stop();
   end
endmodule : reflex_startup_fallback_control_bench
